// ===== bcse_top.sv
// Bus cycle status encoder: drives the cycle status and select pins.
// Assumes a bus unit on the same clock gives start requests; hold ack is a pin.
//
// What this block does
// R1 - Pull status lines low to mark each cycle start, with select pins.
// R2 - Status state is any status line low; controller detects start there.
// R3 - During hold acknowledge, release status lines as high-impedance logic one.
// R4 - Codes: intack 0000, halt 0100, mem rd 0101, wr 0110, io 1001, 1010.
// R5 - Halt code means halt when address bit one is 1, else shutdown.
// R6 - Both status lines high means no status cycle.
// R7 - Never drive reserved codes 0001, 0010 or 1000.
// R8 - Memory/IO select high for memory or halt, low for IO or intack.
// R9 - Code select splits fetch from data read, intack from IO.
`timescale 1ns/100ps
`default_nettype none
`include "bcse_cfg.svh"
module bcse_top (
  input  wire logic               i_ref_clk,    // Processor clock
  input  wire logic               i_rst_b,      // Async reset, active low
  input  wire bcse_pkg::bcse_req_t i_req,       // Cycle start request
  input  wire logic               i_hold_ack,   // Bus hold acknowledge pin
  output logic                    o_address_bit_one, // Address bit one value
  output bcse_pkg::bcse_pins_t    o_pins,       // Pin output values
  output bcse_pkg::bcse_pins_t    o_pins_oe,    // Pin output enables
  output logic                    o_status_state // High during status state
);
  import bcse_pkg::*;

  logic [2:0] hold_sync_reg;
  logic       hold_reg;
  logic [3:0] code_next;
  logic [3:0] code_reg;
  logic [1:0] status_reg;
  logic       a1_reg;

  // Hold pin from outside: three flops, accept when the last two agree
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_sync_reg <= {3{`BCSE_HOLD_RESET}};
    end else begin
      hold_sync_reg <= {hold_sync_reg[1:0], i_hold_ack};
    end
  end

  // Accepted hold level; it moves only once the last two flops agree
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_reg <= `BCSE_HOLD_RESET;
    end else if (hold_sync_reg[2] == hold_sync_reg[1]) begin
      hold_reg <= hold_sync_reg[2];
    end
  end

  // Encode the requested cycle; reserved codes cannot be produced
  always_comb begin
    case (i_req.kind)
      BCSE_INTACK: code_next = `BCSE_CODE_INTACK;  // R4 R8 R9
      BCSE_HALT:   code_next = `BCSE_CODE_HALT;    // R4 R5 R8
      BCSE_MEM_RD: code_next = `BCSE_CODE_MEM_RD;  // R4
      BCSE_MEM_WR: code_next = `BCSE_CODE_MEM_WR;  // R4
      BCSE_FETCH:  code_next = `BCSE_CODE_FETCH;   // R9
      BCSE_IO_RD:  code_next = `BCSE_CODE_IO_RD;   // R4
      BCSE_IO_WR:  code_next = `BCSE_CODE_IO_WR;   // R4
      default:     code_next = `BCSE_CODE_MEM_RD;  // R7
    endcase
  end

  // Status lines low for one cycle per accepted start, idle otherwise
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status_reg <= `BCSE_STATUS_IDLE;
    end else if (i_req.start && !hold_reg) begin
      status_reg <= code_next[`BCSE_POS_HI:`BCSE_POS_LO]; // R1
    end else begin
      status_reg <= `BCSE_STATUS_IDLE;                     // R6
    end
  end

  // Selects and address bit hold their value until the next start taken outside hold
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      code_reg <= {`BCSE_SEL_RESET, `BCSE_STATUS_IDLE};
      a1_reg   <= `BCSE_A1_RESET;
    end else if (i_req.start && !hold_reg) begin
      code_reg <= code_next;                               // R8 R9
      a1_reg   <= (i_req.kind == BCSE_HALT) ? i_req.address_bit_one : 1'h0; // R5
    end
  end

  // During hold, all four pins are released: status values at logic one, selects at last value
  always_comb begin
    o_pins.code_intack_select = code_reg[`BCSE_POS_CODE];
    o_pins.mem_io_select      = code_reg[`BCSE_POS_MEMIO];
    o_pins.cycle_status_hi_b  = hold_reg ? 1'h1 : status_reg[1]; // R3
    o_pins.cycle_status_lo_b  = hold_reg ? 1'h1 : status_reg[0]; // R3
    o_pins_oe                 = hold_reg ? 4'h0 : 4'hF;          // R3
  end

  // Status state follows the pins: a start that meets hold at the same edge
  // is cut short, as its status lines already float at logic one
  assign o_status_state    = !hold_reg && (status_reg != `BCSE_STATUS_IDLE); // R2 R3
  assign o_address_bit_one = a1_reg;                                        // R5

  // Cycle start and status state; a hold taken at the edge after a start
  // floats the lines, so the start check asks for the bus still free then
  a_start_marks: assert property ( // R1
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.start && !hold_reg) ##1 !hold_reg |-> o_status_state)
    else $error("start did not mark status state");
  a_state_def: assert property ( // R2
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    o_status_state == (!o_pins.cycle_status_hi_b || !o_pins.cycle_status_lo_b))
    else $error("status state mismatch");

  // Bus hold: both status lines released at one, starts dropped
  a_hold_float: assert property ( // R3
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    hold_reg |-> (o_pins_oe == 4'h0 && !o_status_state))
    else $error("status driven during hold");
  a_hold_pins: assert property ( // R3
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    hold_reg |-> (o_pins.cycle_status_hi_b && o_pins.cycle_status_lo_b))
    else $error("status lines not at one during hold");
  a_hold_refuse: assert property ( // R3
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.start && hold_reg) |=> !o_status_state)
    else $error("start taken during hold");
  // Hold is taken only once the last two sync flops agree
  a_hold_accept: assert property ( // R3
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    $changed(hold_reg) |-> ($past(hold_sync_reg[2]) == $past(hold_sync_reg[1])))
    else $error("hold taken before its flops agreed");

  // Cycle codes of each kind but fetch, and address bit one for halt only
  // Expected codes are the fixed patterns, not the decoder's own table
  a_intack_code: assert property ( // R4
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.start && !hold_reg && i_req.kind == BCSE_INTACK) |=> code_reg == 4'h0)
    else $error("interrupt acknowledge code wrong");
  a_mem_rd_code: assert property ( // R4
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.start && !hold_reg && i_req.kind == BCSE_MEM_RD) |=> code_reg == 4'h5)
    else $error("memory read code wrong");
  a_mem_wr_code: assert property ( // R4
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.start && !hold_reg && i_req.kind == BCSE_MEM_WR) |=> code_reg == 4'h6)
    else $error("memory write code wrong");
  a_io_rd_code: assert property ( // R4
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.start && !hold_reg && i_req.kind == BCSE_IO_RD) |=> code_reg == 4'h9)
    else $error("io read code wrong");
  a_io_code: assert property ( // R4
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.start && !hold_reg && i_req.kind == BCSE_IO_WR) |=> code_reg == 4'hA)
    else $error("io write code wrong");
  a_halt_a1: assert property ( // R5
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.start && !hold_reg && i_req.kind == BCSE_HALT)
      |=> (code_reg == 4'h4 && a1_reg == $past(i_req.address_bit_one)))
    else $error("halt code or address bit wrong");
  a_other_a1: assert property ( // R5
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.start && !hold_reg && i_req.kind != BCSE_HALT)
      |=> !o_address_bit_one)
    else $error("address bit set outside halt");

  // Idle and reserved patterns
  // Status lines go low for one cycle per start and never show a reserved code
  a_idle_high: assert property ( // R6
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !$past(i_req.start) |-> !o_status_state)
    else $error("status without start");
  a_status_pulse: assert property ( // R6
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (o_status_state && !i_req.start) |=> !o_status_state)
    else $error("status state longer than one cycle");
  a_no_reserved: assert property ( // R7
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    o_status_state |-> !(code_reg inside {4'h1, 4'h2, 4'h8}))
    else $error("reserved code driven");

  // Select lines: set by each start taken outside hold from the kind asked for, held in between
  // The kind is taken from the request itself, so a wrong table entry shows
  a_memio_sel: assert property ( // R8
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.start && !hold_reg) |=> (o_pins.mem_io_select ==
      ($past(i_req.kind) inside {BCSE_HALT, BCSE_MEM_RD, BCSE_MEM_WR, BCSE_FETCH})))
    else $error("memory io select wrong");
  a_sel_stable: assert property ( // R8
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !(i_req.start && !hold_reg) |=> $stable(code_reg[`BCSE_POS_CODE:`BCSE_POS_MEMIO]))
    else $error("select lines moved without a start");
  a_fetch_code: assert property ( // R9
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.start && !hold_reg && i_req.kind == BCSE_FETCH)
      |=> (o_pins.code_intack_select && o_pins.mem_io_select))
    else $error("fetch select wrong");
  a_intack_sel: assert property ( // R9
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_req.start && !hold_reg && i_req.kind == BCSE_INTACK)
      |=> (!o_pins.code_intack_select && !o_pins.mem_io_select))
    else $error("interrupt acknowledge select wrong");

  // Main scenarios: intack, halt and io read cycles, a start refused in hold, and a start
  // meeting a hold that is accepted at the very same edge
  c_intack: cover property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    o_status_state && code_reg == 4'h0);
  c_halt: cover property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    o_status_state && code_reg == 4'h4);
  c_io_rd: cover property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    o_status_state && code_reg == 4'h9);
  c_hold: cover property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    i_req.start && hold_reg);
  c_hold_race: cover property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    i_req.start && !hold_reg && hold_sync_reg[2] && hold_sync_reg[1]);
endmodule : bcse_top
`default_nettype wire

// ===== bcse_cfg.svh
// Constants of the bus cycle status encoder: code positions and cycle codes.
// Assumes inclusion by bcse_pkg.sv and bcse_top.sv only.
`ifndef BCSE_CFG_SVH
`define BCSE_CFG_SVH
// Bit positions inside the four-bit cycle code {code_intack, mem_io, hi, lo}
`define BCSE_POS_CODE   3
`define BCSE_POS_MEMIO  2
`define BCSE_POS_HI     1
`define BCSE_POS_LO     0
// Cycle codes driven at the start of a bus cycle
`define BCSE_CODE_INTACK   4'h0
`define BCSE_CODE_HALT     4'h4
`define BCSE_CODE_MEM_RD   4'h5
`define BCSE_CODE_MEM_WR   4'h6
`define BCSE_CODE_FETCH    4'hD
`define BCSE_CODE_IO_RD    4'h9
`define BCSE_CODE_IO_WR    4'hA
// Idle pattern: both status lines high, selects held
`define BCSE_STATUS_IDLE   2'h3
`define BCSE_SEL_RESET     2'h3
// Reset levels of the hold sync and the latched address bit
`define BCSE_HOLD_RESET    1'h0
`define BCSE_A1_RESET      1'h0
`endif

// ===== bcse_pkg.sv
// Types of the bus cycle status encoder.
// Assumes bcse_cfg.svh is on the include path.
`include "bcse_cfg.svh"
package bcse_pkg;
  // Cycle type requested by the bus unit
  typedef enum logic [2:0] {
    BCSE_INTACK = 3'h0,
    BCSE_HALT   = 3'h1,
    BCSE_MEM_RD = 3'h2,
    BCSE_MEM_WR = 3'h3,
    BCSE_FETCH  = 3'h4,
    BCSE_IO_RD  = 3'h5,
    BCSE_IO_WR  = 3'h6
  } bcse_cycle_t;
  // Request to start a bus cycle
  typedef struct packed {
    logic        start;
    bcse_cycle_t kind;
    logic        address_bit_one;
  } bcse_req_t;
  // Pin group: value, enable
  typedef struct packed {
    logic code_intack_select;
    logic mem_io_select;
    logic cycle_status_hi_b;
    logic cycle_status_lo_b;
  } bcse_pins_t;
endpackage : bcse_pkg

// ===== bcse_ctrl_model.sv
// Bus controller model: decodes the cycle status and select pins.
// Assumes the pin group and enables of bcse_top.
`timescale 1ns/100ps
`default_nettype none
module bcse_ctrl_model (
  input  wire bcse_pkg::bcse_pins_t i_pins, // Pin values
  input  wire bcse_pkg::bcse_pins_t i_oe,   // Pin enables
  output logic                      o_start, // Cycle start seen
  output logic [3:0]                o_code   // Decoded cycle code
);
  import bcse_pkg::*;
  logic [1:0] st;
  // A released status line floats to logic one
  assign st[1] = i_oe.cycle_status_hi_b ? i_pins.cycle_status_hi_b : 1'b1;
  assign st[0] = i_oe.cycle_status_lo_b ? i_pins.cycle_status_lo_b : 1'b1;
  // Start whenever either line is low; both high is no cycle
  assign o_start = ~&st;
  assign o_code = {i_pins.code_intack_select, i_pins.mem_io_select, st};
endmodule : bcse_ctrl_model
`default_nettype wire

// ===== bus_cycle_status_encoder_tb.sv
// Self-checking bench of the bus cycle status encoder.
// Assumes bcse_top and bcse_ctrl_model.
`timescale 1ns/100ps
`default_nettype none
module bus_cycle_status_encoder_tb;
  import bcse_pkg::*;
  logic       i_ref_clk = 1'b0;
  logic       i_rst_b = 1'b0;
  logic       i_hold_ack = 1'b0;
  bcse_req_t  i_req = '0;
  bcse_pins_t pins, oe;
  logic       a1, ts, seen;
  logic [3:0] code;
  int         err_count = 0;
  int         num_checks = 0;
  // Rows: kind, address bit in, cycle code, address bit out
  logic [8:0] rows [9] = '{9'h000, 9'h069, 9'h048, 9'h08A, 9'h0AA, 9'h0CC,
                           9'h11A, 9'h152, 9'h194};
  bcse_top uut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_req(i_req),
    .i_hold_ack(i_hold_ack), .o_address_bit_one(a1), .o_pins(pins),
    .o_pins_oe(oe), .o_status_state(ts));
  bcse_ctrl_model ctrl (.i_pins(pins), .i_oe(oe), .o_start(seen), .o_code(code));
  // Clock of 10 ns
  always #5 i_ref_clk = ~i_ref_clk;
  // Compare one value and count it
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Report and end the run
  task automatic print_verdict;
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  // Reset, table of cycles back to back, idle, then hold
  initial begin
    repeat (8) @(posedge i_ref_clk);
    #1 i_rst_b = 1'b1;
    chk("reset pins", 4'hF, pins);
    chk("reset oe", 4'hF, oe);
    for (int i = 0; i < 9; i++) begin
      i_req = {1'b1, bcse_cycle_t'(rows[i][8:6]), rows[i][5]};
      @(posedge i_ref_clk);
      #1;
      chk("code", rows[i][4:1], code);
      chk("start", 4'h3, {2'h0, seen, ts});
      chk("address bit", {3'h0, rows[i][0]}, {3'h0, a1});
    end
    i_req.start = 1'b0;
    @(posedge i_ref_clk);
    #1;
    chk("idle code", 4'hB, code);
    chk("idle start", 4'h0, {2'h0, seen, ts});
    // Hold accepted at the edge that takes a start: lines float, selects move
    i_hold_ack = 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #1 i_req = {1'b1, BCSE_MEM_WR, 1'b0};
    @(posedge i_ref_clk);
    #1 i_req = {1'b1, BCSE_IO_RD, 1'b0};
    chk("race start", 4'h0, {2'h0, seen, ts});
    chk("hold oe", 4'h0, oe);
    chk("race code", 4'h7, code);
    @(posedge i_ref_clk);
    #1 i_req.start = 1'b0;
    chk("hold start", 4'h0, {2'h0, seen, ts});
    chk("hold code", 4'h7, code);
    // Hold released: lines driven again once the sync flops agree
    i_hold_ack = 1'b0;
    for (int n = 0; n < 8 && oe !== 4'hF; n++) begin
      @(posedge i_ref_clk);
      #1;
    end
    chk("release oe", 4'hF, oe);
    chk("release code", 4'h7, code);
    // Reset in mid-run; the start held across it is taken at the first edge
    i_req = {1'b1, BCSE_HALT, 1'b1};
    @(posedge i_ref_clk);
    #1 i_rst_b = 1'b0;
    #1;
    chk("mid reset pins", 4'hF, pins);
    chk("mid reset start", 4'h0, {2'h0, seen, ts});
    chk("mid reset bit", 4'h0, {3'h0, a1});
    repeat (2) @(posedge i_ref_clk);
    #1 i_rst_b = 1'b1;
    @(posedge i_ref_clk);
    #1 i_req.start = 1'b0;
    chk("first code", 4'h4, code);
    chk("first bit", 4'h1, {3'h0, a1});
    chk("first start", 4'h3, {2'h0, seen, ts});
    @(posedge i_ref_clk);
    #1;
    chk("after code", 4'h7, code);
    chk("after start", 4'h0, {2'h0, seen, ts});
    print_verdict();
  end
endmodule : bus_cycle_status_encoder_tb
`default_nettype wire
